// ---- core/panel_cmd_pkg.sv ----
// constants and field layout of the panel sense and update commands
package panel_cmd_pkg;
   localparam logic [7:0] CMD_SUPPLY_DETECT = 8'h15;
   localparam logic [7:0] CMD_SENSOR_SEL = 8'h18;
   localparam logic [7:0] CMD_TEMP_WRITE = 8'h1A;
   localparam logic [7:0] CMD_TEMP_READ = 8'h1B;
   localparam logic [7:0] CMD_UPDATE_RUN = 8'h20;
   localparam logic [7:0] CMD_UPDATE_OPTION = 8'h22;
   localparam logic [7:0] CMD_STATUS_READ = 8'h2F;
   localparam logic [2:0] LEVEL_RST = 3'h4;
   localparam logic [2:0] LEVEL_MIN = 3'h3;
   localparam logic [7:0] SENSOR_RST = 8'h48;
   localparam logic [7:0] SENSOR_INTERNAL = 8'h80;
   localparam logic [11:0] TEMP_RST = 12'h7FF;
   localparam logic [7:0] OPTION_RST = 8'hC7;
   localparam int STATUS_SUPPLY_LOW_BIT = 0;
   localparam logic [2:0] STEP_CLOCK_ON = 3'h7;
   localparam logic [2:0] STEP_ANALOG_ON = 3'h6;
   localparam logic [2:0] STEP_LOAD_TEMP = 3'h5;
   localparam logic [2:0] STEP_DISPLAY = 3'h2;
   localparam logic [2:0] STEP_ANALOG_OFF = 3'h1;
   localparam logic [2:0] STEP_CLOCK_OFF = 3'h0;
   localparam int CLK_PERIOD_NS = 25;
   localparam int DETECT_TIME_NS = 100000;
   localparam int DETECT_CYCLES =
      (DETECT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int STEP_TIME_NS = 50000;
   localparam int STEP_CYCLES =
      (STEP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

// ---- core/spi_byte_link.sv ----
// three-wire serial byte receiver and read-back shifter
`timescale 1ns/1ps
`default_nettype none
module spi_byte_link (
   // clock and reset
   input wire logic clk_sys,
   input wire logic arst_n,
   // pins, inputs asynchronous to clk_sys, outputs driven from clk_sys flops
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic sda_in,
   input wire logic dc,
   input wire logic rw,
   output logic sda_out,
   output logic sda_oe,
   // byte side
   input wire logic [7:0] tx_byte,
   output logic rx_valid,
   output logic [7:0] rx_byte,
   output logic rx_is_param,
   output logic rx_is_read
);
   typedef struct packed {
      logic [4:0] s1;
      logic [4:0] s2;
      logic sclk_d;
      logic cs_d;
      logic [2:0] bit_cnt;
      logic [7:0] rx_sh;
      logic [7:0] tx_sh;
      logic rx_valid;
      logic [7:0] rx_byte;
      logic is_param;
      logic is_read;
   } link_state_type;
   link_state_type q_ff, nxt_q;
   logic active, rise, fall;

   // synchronise pins, find clock edges, shift bytes in and out
   always_comb begin
      nxt_q = q_ff;
      nxt_q.s1 = {sclk, cs_n, sda_in, dc, rw};
      nxt_q.s2 = q_ff.s1;
      nxt_q.sclk_d = q_ff.s2[4];
      nxt_q.cs_d = q_ff.s2[3];
      nxt_q.rx_valid = 1'b0;
      active = !q_ff.s2[3];
      rise = q_ff.s2[4] && !q_ff.sclk_d;
      fall = !q_ff.s2[4] && q_ff.sclk_d;
      if (!active) begin
         nxt_q.bit_cnt = 3'h0;
      end else if (q_ff.cs_d) begin
         nxt_q.bit_cnt = 3'h0;
         nxt_q.tx_sh = tx_byte;
      end else if (rise) begin
         nxt_q.rx_sh = {q_ff.rx_sh[6:0], q_ff.s2[2]};
         nxt_q.bit_cnt = q_ff.bit_cnt + 3'h1;
         if (q_ff.bit_cnt == 3'h7) begin
            nxt_q.rx_valid = 1'b1;
            nxt_q.rx_byte = {q_ff.rx_sh[6:0], q_ff.s2[2]};
            nxt_q.is_param = q_ff.s2[1];
            nxt_q.is_read = q_ff.s2[0];
         end
      end else if (fall) begin
         if (q_ff.bit_cnt == 3'h0) begin
            nxt_q.tx_sh = tx_byte;
         end else begin
            nxt_q.tx_sh = {q_ff.tx_sh[6:0], 1'b0};
         end
      end
   end

   // state register
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         q_ff <= '0;
         // idle pins: select high, clock low, so no false edge after reset
         q_ff.s1 <= 5'h08;
         q_ff.s2 <= 5'h08;
         q_ff.cs_d <= 1'b1;
      end else begin
         q_ff <= nxt_q;
      end
   end

   assign sda_out = q_ff.tx_sh[7];
   assign sda_oe = !q_ff.s2[3] && q_ff.s2[0];
   assign rx_valid = q_ff.rx_valid;
   assign rx_byte = q_ff.rx_byte;
   assign rx_is_param = q_ff.is_param;
   assign rx_is_read = q_ff.is_read;
endmodule // spi_byte_link
`default_nettype wire

// ---- core/update_sequencer.sv ----
// walks the enabled steps of the display update option byte
`timescale 1ns/1ps
`default_nettype none
module update_sequencer import panel_cmd_pkg::*; #(
   parameter int STEP_LEN = STEP_CYCLES
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic arst_n,
   // control
   input wire logic start,
   input wire logic [7:0] option,
   output logic running,
   output logic done,
   // panel controls
   output logic clock_on,
   output logic analog_on,
   output logic load_temp,
   output logic display_pulse
);
   localparam logic [11:0] STEP_LAST = 12'(STEP_LEN - 1);
   typedef struct packed {
      logic run;
      logic [7:0] opt;
      logic [2:0] idx;
      logic [11:0] cnt;
      logic clk_on;
      logic ana_on;
      logic load;
      logic disp;
      logic done;
   } seq_state_type;
   seq_state_type q_ff, nxt_q;

   // one step per set option bit, highest bit first
   always_comb begin
      nxt_q = q_ff;
      nxt_q.load = 1'b0;
      nxt_q.disp = 1'b0;
      nxt_q.done = 1'b0;
      if (!q_ff.run) begin
         if (start) begin
            nxt_q.run = 1'b1;
            nxt_q.opt = option;
            nxt_q.idx = 3'h7;
            nxt_q.cnt = STEP_LAST;
         end
      end else if (q_ff.opt[q_ff.idx] && q_ff.cnt != 12'h0) begin
         nxt_q.cnt = q_ff.cnt - 12'h1;
      end else begin
         if (q_ff.opt[q_ff.idx]) begin
            case (q_ff.idx)
               STEP_CLOCK_ON: nxt_q.clk_on = 1'b1;
               STEP_ANALOG_ON: nxt_q.ana_on = 1'b1;
               STEP_LOAD_TEMP: nxt_q.load = 1'b1;
               STEP_DISPLAY: nxt_q.disp = 1'b1;
               STEP_ANALOG_OFF: nxt_q.ana_on = 1'b0;
               STEP_CLOCK_OFF: nxt_q.clk_on = 1'b0;
               default: nxt_q.cnt = STEP_LAST;
            endcase
         end
         if (q_ff.idx == 3'h0) begin
            nxt_q.run = 1'b0;
            nxt_q.done = 1'b1;
         end else begin
            nxt_q.idx = q_ff.idx - 3'h1;
            nxt_q.cnt = STEP_LAST;
         end
      end
   end

   // state register
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         q_ff <= '0;
      end else begin
         q_ff <= nxt_q;
      end
   end

   assign running = q_ff.run;
   assign done = q_ff.done;
   assign clock_on = q_ff.clk_on;
   assign analog_on = q_ff.ana_on;
   assign load_temp = q_ff.load;
   assign display_pulse = q_ff.disp;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!arst_n);
   AST_SKIP_DISABLED: assert property (
      q_ff.run && !q_ff.opt[q_ff.idx] |=> !q_ff.run ||
         q_ff.idx == $past(q_ff.idx) - 3'h1)
      else $error("disabled step not skipped");
endmodule // update_sequencer
`default_nettype wire

// ---- core/panel_sense_and_update_commands.sv ----
// command decoder for supply detection, temperature and update commands
`timescale 1ns/1ps
`default_nettype none
module panel_sense_and_update_commands import panel_cmd_pkg::*; #(
   parameter int DETECT_LEN = DETECT_CYCLES,
   parameter int STEP_LEN = STEP_CYCLES
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic arst_n,
   // serial command pins
   input wire logic spi_sclk,
   input wire logic spi_cs_n,
   input wire logic spi_dc,
   input wire logic spi_rw,
   input wire logic spi_sda_in,
   output logic spi_sda_out,
   output logic spi_sda_oe,
   // busy towards the host
   output logic busy,
   // supply comparator
   output logic [2:0] supply_level,
   output logic detect_active,
   input wire logic supply_above,
   // temperature
   input wire logic [11:0] sensor_temp,
   output logic sensor_internal_sel,
   // panel controls
   output logic internal_clock_on_flag,
   output logic analog_block_on_flag,
   output logic display_drive_pulse
);
   localparam logic [11:0] DETECT_LAST = 12'(DETECT_LEN - 1);

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_DETECT,
      ST_UPDATE
   } cmd_state_type;

   typedef struct packed {
      cmd_state_type state;
      logic [7:0] cmd;
      logic pidx;
      logic [2:0] level;
      logic [7:0] sensor;
      logic [11:0] temp;
      logic [7:0] temp_hi;
      logic [7:0] option;
      logic [11:0] cnt;
      logic supply_low;
      logic sup_s1;
      logic sup_s2;
      logic [7:0] tx;
      logic run_go;
   } main_state_type;

   main_state_type q_ff, nxt_q;
   logic rx_valid, rx_is_param, rx_is_read;
   logic [7:0] rx_byte;
   logic seq_running, seq_done, seq_load;

   // a level code below 011 names no threshold
   function automatic logic level_ok(input logic [2:0] code);
      level_ok = code >= LEVEL_MIN;
   endfunction

   // serial byte link towards the host
   spi_byte_link u_link (
      .clk_sys(clk_sys),
      .arst_n(arst_n),
      .sclk(spi_sclk),
      .cs_n(spi_cs_n),
      .sda_in(spi_sda_in),
      .dc(spi_dc),
      .rw(spi_rw),
      .sda_out(spi_sda_out),
      .sda_oe(spi_sda_oe),
      .tx_byte(q_ff.tx),
      .rx_valid(rx_valid),
      .rx_byte(rx_byte),
      .rx_is_param(rx_is_param),
      .rx_is_read(rx_is_read)
   );

   // display update step walker
   update_sequencer #(
      .STEP_LEN(STEP_LEN)
   ) u_seq (
      .clk_sys(clk_sys),
      .arst_n(arst_n),
      .start(q_ff.run_go),
      .option(q_ff.option),
      .running(seq_running),
      .done(seq_done),
      .clock_on(internal_clock_on_flag),
      .analog_on(analog_block_on_flag),
      .load_temp(seq_load),
      .display_pulse(display_drive_pulse)
   );

   // command decode, parameter capture, detection timer, update wait
   always_comb begin
      nxt_q = q_ff;
      nxt_q.sup_s1 = supply_above;
      nxt_q.sup_s2 = q_ff.sup_s1;
      nxt_q.run_go = 1'b0;
      case (q_ff.state)
         ST_IDLE: begin
            if (rx_valid && !rx_is_param) begin
               nxt_q.cmd = rx_byte;
               nxt_q.pidx = 1'b0;
               nxt_q.tx = 8'h00;
               if (rx_byte == CMD_UPDATE_RUN) begin
                  nxt_q.state = ST_UPDATE;
                  nxt_q.run_go = 1'b1;
               end
               if (rx_byte == CMD_TEMP_READ) begin
                  nxt_q.tx = q_ff.temp[11:4];
               end
               if (rx_byte == CMD_STATUS_READ) begin
                  nxt_q.tx[STATUS_SUPPLY_LOW_BIT] = q_ff.supply_low;
               end
            end else if (rx_valid) begin
               nxt_q.pidx = 1'b1;
               nxt_q.tx = 8'h00;
               case (q_ff.cmd)
                  CMD_SUPPLY_DETECT: begin
                     if (!rx_is_read && level_ok(rx_byte[2:0])) begin
                        nxt_q.level = rx_byte[2:0];
                        nxt_q.state = ST_DETECT;
                        nxt_q.cnt = DETECT_LAST;
                     end
                  end
                  CMD_SENSOR_SEL: begin
                     if (!rx_is_read) begin
                        nxt_q.sensor = rx_byte;
                     end
                  end
                  CMD_TEMP_WRITE: begin
                     if (!rx_is_read && !q_ff.pidx) begin
                        nxt_q.temp_hi = rx_byte;
                     end else if (!rx_is_read) begin
                        nxt_q.temp = {q_ff.temp_hi, rx_byte[7:4]};
                     end
                  end
                  CMD_TEMP_READ: begin
                     if (rx_is_read && !q_ff.pidx) begin
                        nxt_q.tx = {q_ff.temp[3:0], 4'h0};
                     end
                  end
                  CMD_UPDATE_OPTION: begin
                     if (!rx_is_read) begin
                        nxt_q.option = rx_byte;
                     end
                  end
                  default: nxt_q.pidx = 1'b1;
               endcase
            end
         end
         ST_DETECT: begin
            if (q_ff.cnt != 12'h0) begin
               nxt_q.cnt = q_ff.cnt - 12'h1;
            end else begin
               nxt_q.supply_low = !q_ff.sup_s2;
               nxt_q.state = ST_IDLE;
            end
         end
         ST_UPDATE: begin
            if (seq_load && q_ff.sensor == SENSOR_INTERNAL) begin
               nxt_q.temp = sensor_temp;
            end
            if (seq_done) begin
               nxt_q.state = ST_IDLE;
            end
         end
         default: nxt_q.state = ST_IDLE;
      endcase
   end

   // state register with power-on values
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         q_ff <= '0;
         q_ff.state <= ST_IDLE;
         q_ff.level <= LEVEL_RST;
         q_ff.sensor <= SENSOR_RST;
         q_ff.temp <= TEMP_RST;
         q_ff.option <= OPTION_RST;
      end else begin
         q_ff <= nxt_q;
      end
   end

   // outputs, busy while detecting or updating
   assign busy = q_ff.state != ST_IDLE;
   assign detect_active = q_ff.state == ST_DETECT;
   assign supply_level = q_ff.level;
   assign sensor_internal_sel = q_ff.sensor == SENSOR_INTERNAL;

   // helper: cycles spent in one detection
   logic [12:0] det_len_ff;
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         det_len_ff <= 13'h0;
      end else if (q_ff.state == ST_DETECT) begin
         det_len_ff <= det_len_ff + 13'h1;
      end else begin
         det_len_ff <= 13'h0;
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!arst_n);

   AST_BAD_LEVEL_KEPT: assert property (
      rx_valid && rx_is_param && q_ff.cmd == CMD_SUPPLY_DETECT &&
      !busy && !level_ok(rx_byte[2:0]) |=> $stable(q_ff.level) && !busy)
      else $error("invalid level accepted");
   AST_DETECT_START: assert property (
      rx_valid && rx_is_param && !rx_is_read && !busy &&
      q_ff.cmd == CMD_SUPPLY_DETECT && level_ok(rx_byte[2:0])
      |=> detect_active && busy && supply_level == $past(rx_byte[2:0]))
      else $error("detection did not start");
   AST_DETECT_LENGTH: assert property (
      $fell(detect_active) |-> !busy &&
         $past(det_len_ff) == 13'(DETECT_LEN - 1))
      else $error("detection length wrong");
   AST_RESULT_BIT: assert property (
      $fell(detect_active) |-> q_ff.supply_low == !$past(q_ff.sup_s2))
      else $error("detection result not stored");
   AST_SENSOR_SEL: assert property (
      rx_valid && rx_is_param && !rx_is_read && !busy &&
      q_ff.cmd == CMD_SENSOR_SEL |=> q_ff.sensor == $past(rx_byte))
      else $error("sensor selection not taken");
   AST_TEMP_WRITE: assert property (
      rx_valid && rx_is_param && !rx_is_read && !busy && q_ff.pidx &&
      q_ff.cmd == CMD_TEMP_WRITE |=>
      q_ff.temp == {$past(q_ff.temp_hi), $past(rx_byte[7:4])})
      else $error("temperature not assembled");
   AST_TEMP_READ: assert property (
      rx_valid && !rx_is_param && !busy && rx_byte == CMD_TEMP_READ
      |=> q_ff.tx == q_ff.temp[11:4])
      else $error("temperature high byte not loaded");
   AST_UPDATE_START: assert property (
      rx_valid && !rx_is_param && !busy && rx_byte == CMD_UPDATE_RUN
      |=> busy ##1 seq_running)
      else $error("update sequence not started");
   AST_BUSY_GUARD: assert property (
      busy && rx_valid |=> $stable(q_ff.option) &&
         $stable(q_ff.level) && $stable(q_ff.sensor) && $stable(q_ff.cmd))
      else $error("byte taken while busy");
   AST_UPDATE_END: assert property (
      q_ff.state == ST_UPDATE && seq_done |=> !busy)
      else $error("busy not released after update");
endmodule // panel_sense_and_update_commands
`default_nettype wire

// ---- dv/panel_host_model.sv ----
// host model that drives the three-wire command link
`timescale 1ns/1ps
`default_nettype none
module panel_host_model (
   // clock
   input wire logic clk_sys,
   // serial pins
   output logic spi_sclk,
   output logic spi_cs_n,
   output logic spi_dc,
   output logic spi_rw,
   output logic sda_drv,
   input wire logic sda_line,
   // device status
   input wire logic busy
);
   localparam int HALF = 6;
   // idle pins: clock parked low outside frames
   initial begin
      spi_sclk = 1'b0;
      spi_cs_n = 1'b1;
      spi_dc = 1'b0;
      spi_rw = 1'b0;
      sda_drv = 1'b0;
   end
   // one byte, msb first; a released data line toggles
   task automatic xfer(input logic [7:0] tx, input logic dcv,
                       input logic rwv, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         @(posedge clk_sys);
         spi_dc <= dcv;
         spi_rw <= rwv;
         sda_drv <= rwv ? ~sda_drv : tx[i];
         repeat (HALF - 1) @(posedge clk_sys);
         @(negedge clk_sys) rx[i] = sda_line;
         @(posedge clk_sys) spi_sclk <= 1'b1;
         repeat (HALF) @(posedge clk_sys);
         spi_sclk <= 1'b0;
      end
   endtask
   // frame edges with settle time around them
   task automatic frame(input logic on);
      repeat (HALF) @(posedge clk_sys);
      spi_cs_n <= ~on;
      spi_rw <= 1'b0;
      repeat (HALF) @(posedge clk_sys);
   endtask
   // command byte with up to two parameters in one frame
   task automatic cmd(input logic [7:0] c, input int n,
                      input logic [7:0] p0, input logic [7:0] p1);
      logic [7:0] d;
      frame(1'b1);
      xfer(c, 1'b0, 1'b0, d);
      if (n > 0) xfer(p0, 1'b1, 1'b0, d);
      if (n > 1) xfer(p1, 1'b1, 1'b0, d);
      frame(1'b0);
   endtask
   // command byte followed by two read bytes
   task automatic rd(input logic [7:0] c, output logic [7:0] b0,
                     output logic [7:0] b1);
      logic [7:0] d;
      frame(1'b1);
      xfer(c, 1'b0, 1'b0, d);
      xfer(8'h00, 1'b1, 1'b1, b0);
      xfer(8'h00, 1'b1, 1'b1, b1);
      frame(1'b0);
   endtask
   // wait for busy low, counting the busy cycles
   task automatic wait_idle(output int n);
      n = 0;
      @(negedge clk_sys);
      while (busy === 1'b1 && n < 5000) begin
         n++;
         @(negedge clk_sys);
      end
   endtask
endmodule // panel_host_model
`default_nettype wire

// ---- dv/testbench.sv ----
// self-checking bench for the panel command decoder
`timescale 1ns/1ps
`default_nettype none
module testbench import panel_cmd_pkg::*; ;
   localparam int DLEN = 300;
   localparam int SLEN = 10;
   localparam int LIMIT = 60000;
   logic clk_sys = 1'b0;
   logic arst_n = 1'b0;
   logic supply_above = 1'b0;
   logic [11:0] sensor_temp = 12'h000;
   logic [7:0] b0, b1;
   wire logic sclk, cs_n, dc, rw, sda_drv, sda_line, sda_out, sda_oe;
   wire logic busy, det, int_sel, clk_flag, ana_flag, pulse;
   wire logic [2:0] level;
   int errors = 0;
   int num_checks = 0;
   int cycles = 0;
   int pulses = 0;
   int n;
   int busy_len = 0;
   int last_busy = 0;
   // resolved data wire
   assign sda_line = sda_oe ? sda_out : sda_drv;
   always #12.5 clk_sys = ~clk_sys;
   panel_host_model host (.clk_sys(clk_sys), .spi_sclk(sclk),
      .spi_cs_n(cs_n), .spi_dc(dc), .spi_rw(rw), .sda_drv(sda_drv),
      .sda_line(sda_line), .busy(busy));
   panel_sense_and_update_commands #(.DETECT_LEN(DLEN), .STEP_LEN(SLEN))
   uut (.clk_sys(clk_sys), .arst_n(arst_n), .spi_sclk(sclk),
      .spi_cs_n(cs_n), .spi_dc(dc), .spi_rw(rw), .spi_sda_in(sda_line),
      .spi_sda_out(sda_out), .spi_sda_oe(sda_oe), .busy(busy),
      .supply_level(level), .detect_active(det),
      .supply_above(supply_above), .sensor_temp(sensor_temp),
      .sensor_internal_sel(int_sel), .internal_clock_on_flag(clk_flag),
      .analog_block_on_flag(ana_flag), .display_drive_pulse(pulse));
   // timeout and display pulse count
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == LIMIT) begin
         errors++;
         end_sim();
      end
   end
   always @(negedge clk_sys) begin
      if (pulse === 1'b1) pulses++;
      // length of the last busy period, in cycles
      if (busy === 1'b1) begin
         busy_len++;
      end else if (busy_len != 0) begin
         last_busy = busy_len;
         busy_len = 0;
      end
   end
   task automatic check(input logic [15:0] seen, input logic [15:0] exp,
                        input string msg);
      num_checks++;
      if (seen !== exp) begin
         errors++;
         $display("CHECK FAILED t=%0t %s seen %h exp %h", $time, msg,
                  seen, exp);
      end
   endtask
   task automatic end_sim();
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // power-on values and temperature read-back
   task automatic t_reset();
      @(negedge clk_sys);
      check(busy, 1'b0, "busy at reset");
      check(level, LEVEL_RST, "level at reset");
      check(int_sel, 1'b0, "sensor at reset");
      check({clk_flag, ana_flag}, 2'b00, "flags at reset");
      host.rd(CMD_TEMP_READ, b0, b1);
      check({b0, b1}, {TEMP_RST, 4'h0}, "temp at reset");
      $display("test reset done");
   endtask
   // default option run, then clock and analog only
   task automatic t_update();
      host.cmd(CMD_UPDATE_RUN, 0, 8'h00, 8'h00);
      check(busy, 1'b1, "busy in update");
      host.wait_idle(n);
      @(negedge clk_sys);
      // set steps take SLEN, clear ones one cycle, plus one start cycle and one done cycle
      check(last_busy, 5 * SLEN + 5, "update length");
      check(pulses, 1, "one display pulse");
      check({clk_flag, ana_flag}, 2'b00, "flags off");
      host.cmd(CMD_UPDATE_OPTION, 1, 8'hC0, 8'h00);
      host.cmd(CMD_UPDATE_RUN, 0, 8'h00, 8'h00);
      host.wait_idle(n);
      @(negedge clk_sys);
      check(last_busy, 2 * SLEN + 8, "short run");
      check(pulses, 1, "no display step");
      check({clk_flag, ana_flag}, 2'b11, "flags on");
      $display("test update done");
   endtask
   // every level code, valid and not, with status read-back after each valid one
   task automatic t_detect();
      logic [2:0] exp_lvl;
      exp_lvl = LEVEL_RST;
      for (int c = 0; c < 8; c++) begin
         @(posedge clk_sys) supply_above <= c[0];
         host.cmd(CMD_SUPPLY_DETECT, 1, {5'h00, c[2:0]}, 8'h00);
         @(negedge clk_sys);
         if (c >= 3) begin
            exp_lvl = c[2:0];
            check({busy, det}, 2'b11, "detect started");
            host.wait_idle(n);
            @(negedge clk_sys);
            check(last_busy, DLEN, "detect length");
            check(det, 1'b0, "detect ended");
            host.rd(CMD_STATUS_READ, b0, b1);
            check(b0, {7'h00, ~c[0]}, "supply status");
         end else begin
            check(busy, 1'b0, "invalid code refused");
         end
         check(level, exp_lvl, "level code");
      end
      $display("test detect done");
   endtask
   // temperature write, sensor choice, load step, refusal while busy
   task automatic t_temp();
      host.cmd(CMD_TEMP_WRITE, 2, 8'hA5, 8'hB0);
      host.rd(CMD_TEMP_READ, b0, b1);
      check({b0, b1}, 16'hA5B0, "temp written");
      host.cmd(CMD_SENSOR_SEL, 1, SENSOR_INTERNAL, 8'h00);
      check(int_sel, 1'b1, "internal sensor");
      @(posedge clk_sys) sensor_temp <= 12'h3C9;
      host.cmd(CMD_UPDATE_OPTION, 1, 8'h20, 8'h00);
      host.cmd(CMD_UPDATE_RUN, 0, 8'h00, 8'h00);
      host.wait_idle(n);
      @(negedge clk_sys);
      check(last_busy, SLEN + 9, "load run length");
      host.rd(CMD_TEMP_READ, b0, b1);
      check({b0, b1}, 16'h3C90, "temp loaded");
      host.cmd(CMD_SENSOR_SEL, 1, SENSOR_RST, 8'h00);
      check(int_sel, 1'b0, "external sensor");
      host.cmd(CMD_SUPPLY_DETECT, 1, 8'h05, 8'h00);
      host.cmd(CMD_SENSOR_SEL, 1, SENSOR_INTERNAL, 8'h00);
      host.wait_idle(n);
      check(int_sel, 1'b0, "ignored while busy");
      $display("test temp done");
   endtask
   // reset, then the scenarios in turn
   initial begin
      repeat (20) @(posedge clk_sys);
      arst_n <= 1'b1;
      repeat (3) @(posedge clk_sys);
      t_reset();
      t_update();
      t_detect();
      t_temp();
      end_sim();
   end
endmodule // testbench
`default_nettype wire
